// ===== rtl/rbd_pkg.sv
package rbd_pkg;
	// decoder region boundaries
	localparam logic [31:0] INT_END = 32'h0040_0000;
	localparam logic [31:0] EXT_BASE = 32'h0040_0000;
	localparam logic [31:0] PER_BASE = 32'hFFC0_0000;
	localparam logic [31:0] HUB_BASE = 32'hFFFF_F000;
	localparam logic [31:0] PER_RSV_BASE = 32'hFFFF_C000;
	// megabyte slots inside the internal region
	localparam logic [1:0] LOW_MB = 2'h0;
	localparam logic [1:0] RAM_BOOT_MB = 2'h3;
	localparam int MB_LO = 20;
	localparam int MB_HI = 21;
	// internal sram: 8 kbyte, 32 bits wide
	localparam int RAM_AW = 11;
	localparam int RAM_WORDS = 2048;
	localparam int RAM_TOP = 13;
	// peripheral slots: 16 kbyte each
	localparam int SLOT_LO = 14;
	localparam int SLOT_HI = 21;
	// external bank arrangements
	localparam logic [1:0] BANKS_1M = 2'h0;
	localparam logic [1:0] BANKS_4M = 2'h1;
	localparam int SHIFT_1M = 20;
	localparam int SHIFT_4M = 22;
	localparam int SHIFT_16M = 24;
	localparam logic [11:0] CNT_8 = 12'h008;
	localparam logic [11:0] CNT_4 = 12'h004;
	// strap window length in clock cycles
	localparam int STRAP_CYCLES = 10;
	// access sizes
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [3:0] BE_BYTE = 4'h1;
	localparam logic [3:0] BE_HALF = 4'h3;
	localparam logic [3:0] BE_WORD = 4'hF;
	// transaction states
	typedef enum logic [1:0] {
		RBD_IDLE = 2'h0,
		RBD_WAIT_EBU = 2'h1,
		RBD_WAIT_PER = 2'h2
	} rbd_state_t;
endpackage

// ===== rtl/rbd_sram.sv
`timescale 1ns/1ps
`default_nettype none
module rbd_sram (
	input wire logic clk,
	input wire logic en,
	input wire logic wr,
	input wire logic [3:0] be,
	input wire logic [rbd_pkg::RAM_AW-1:0] addr,
	input wire logic [31:0] wdata,
	output logic [31:0] rdata
);
	// one array per byte lane, lane 0 is the lowest address byte;
	// separate arrays keep every lane's storage to a single writer
	for (genvar b = 0; b < 4; b++) begin : g_lane
		logic [7:0] lane_mem [rbd_pkg::RAM_WORDS];
		logic [7:0] q_ff;
		always_ff @(posedge clk) begin
			if (en && wr && be[b]) begin
				lane_mem[addr] <= wdata[8*b +: 8];
			end
			if (en && !wr) begin
				q_ff <= lane_mem[addr]; // registered read, answer one cycle later
			end
		end
	end

	// lanes joined little-endian, lane 0 in the low byte
	assign rdata = {g_lane[3].q_ff, g_lane[2].q_ff, g_lane[1].q_ff, g_lane[0].q_ff};
endmodule
`default_nettype wire

// ===== rtl/rbd_decoder.sv
// Overview of operation
// - pin reset asserts async, releases on clock
// - watchdog reset keeps both latched strap modes
// - pin reset wins over watchdog reset
// - strap low ten cycles floats all outputs
// - boot strap picks 8 or 16 bit
// - boot strap pin becomes gpio after reset
// - address zero decodes to boot memory first
// - three regions: internal, external, peripherals
// - middle window goes to external bus unit after remap
// - external banks from 8x1M to 4x16M
// - little endian byte lanes only
// - 8k sram answers in one cycle
// - vector area writable ram after remap
// - remap command bit puts ram at zero, boot memory leaves the internal region
// - chip selects one to seven need remap
// - remap persists until any reset
// - undefined external address raises abort
// - no abort internal or peripheral space
// - peripheral accesses forced to whole words
// - 16k peripheral slots, 4k hub slot
// - boot map cs0 low, ram at 0x300000
`timescale 1ns/1ps
`default_nettype none
module rbd_decoder (
	input wire logic clk,
	input wire logic rst,
	input wire logic watchdog_reset_req,
	input wire logic float_outputs_strap_n,
	input wire logic boot_width_strap,
	output logic core_reset,
	output logic outputs_disabled,
	output logic boot_bus_8bit,
	output logic port_b_line_eighteen_gpio_en,
	input wire logic remap_ctrl_wr,
	input wire logic remap_command_bit,
	output logic remap_active,
	input wire logic [1:0] bank_size_sel,
	input wire logic cpu_req,
	input wire logic cpu_instr,
	input wire logic cpu_write,
	input wire logic [1:0] cpu_size,
	input wire logic [31:0] cpu_addr,
	input wire logic [31:0] cpu_wdata,
	output logic cpu_ack,
	output logic [31:0] cpu_rdata,
	output logic data_abort,
	output logic prefetch_abort,
	output logic ebu_req,
	output logic ebu_write,
	output logic [1:0] ebu_size,
	output logic [31:0] ebu_addr,
	output logic [31:0] ebu_wdata,
	output logic [7:0] ebu_cs_n,
	input wire logic ebu_ack,
	input wire logic [31:0] ebu_rdata,
	output logic per_req,
	output logic per_write,
	output logic [31:0] per_addr,
	output logic [31:0] per_wdata,
	output logic [7:0] per_slot,
	output logic per_hub_sel,
	input wire logic per_ack,
	input wire logic [31:0] per_rdata
);
	localparam int HW = rbd_pkg::STRAP_CYCLES;

	logic rst_meta_ff, rst_hold_ff, rst_dly_ff;
	logic float_meta_ff, float_sync_ff, boot_meta_ff, boot_sync_ff;
	logic [HW-1:0] float_hist_ff, boot_hist_ff;
	logic float_mode_ff, boot8_mode_ff, nxt_float_mode, nxt_boot8_mode;
	logic release_edge, sys_clr, float_all_low;
	rbd_pkg::rbd_state_t state_ff, nxt_state;
	logic remap_ff, nxt_remap;
	logic ack_ff, nxt_ack, dab_ff, nxt_dab, pab_ff, nxt_pab;
	logic ram_rd_ff, nxt_ram_rd;
	logic [31:0] rdata_ff, nxt_rdata;
	logic ebu_req_ff, nxt_ebu_req, ebu_wr_ff, nxt_ebu_wr;
	logic [1:0] ebu_size_ff, nxt_ebu_size;
	logic [31:0] ebu_addr_ff, nxt_ebu_addr, ebu_wdata_ff, nxt_ebu_wdata;
	logic [7:0] ebu_cs_n_ff, nxt_ebu_cs_n;
	logic per_req_ff, nxt_per_req, per_wr_ff, nxt_per_wr, hub_ff, nxt_hub;
	logic [31:0] per_addr_ff, nxt_per_addr, per_wdata_ff, nxt_per_wdata;
	logic [7:0] slot_ff, nxt_slot;
	logic in_int, in_per, ram_hit, cs0_hit, bank_ok;
	logic [1:0] mb;
	logic [31:0] ext_off;
	logic [11:0] bank_idx, bank_cnt;
	logic [3:0] ram_be;
	logic ram_en;
	logic [31:0] ram_q;

	// pin reset: async assert, release through two flops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rst_meta_ff <= 1'b1;
			rst_hold_ff <= 1'b1;
			rst_dly_ff <= 1'b1;
		end else begin
			rst_meta_ff <= 1'b0;
			rst_hold_ff <= rst_meta_ff;
			rst_dly_ff <= rst_hold_ff; // edge finder never reads the metastable flop
		end
	end

	// the straps must be watched while the pin is high, so no reset here
	always_ff @(posedge clk) begin
		float_meta_ff <= float_outputs_strap_n;
		float_sync_ff <= float_meta_ff;
		boot_meta_ff <= boot_width_strap;
		boot_sync_ff <= boot_meta_ff;
		float_hist_ff <= {float_hist_ff[HW-2:0], float_sync_ff};
		boot_hist_ff <= {boot_hist_ff[HW-2:0], boot_sync_ff};
	end

	// straps are only taken on the pin release, never by the watchdog
	assign release_edge = rst_dly_ff && !rst_hold_ff;
	assign sys_clr = rst_hold_ff || watchdog_reset_req;
	assign float_all_low = (float_hist_ff == '0);

	// mode capture at release; watchdog leaves both modes alone
	always_comb begin
		nxt_float_mode = float_mode_ff;
		nxt_boot8_mode = boot8_mode_ff;
		if (release_edge) begin
			nxt_float_mode = float_all_low;
			nxt_boot8_mode = boot_hist_ff[0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			float_mode_ff <= 1'b0;
			boot8_mode_ff <= 1'b0;
		end else begin
			float_mode_ff <= nxt_float_mode;
			boot8_mode_ff <= nxt_boot8_mode;
		end
	end

	// region and bank decode of the core address
	always_comb begin
		in_int = (cpu_addr < rbd_pkg::INT_END);
		in_per = (cpu_addr >= rbd_pkg::PER_BASE);
		mb = cpu_addr[rbd_pkg::MB_HI:rbd_pkg::MB_LO];
		cs0_hit = !remap_ff && (mb == rbd_pkg::LOW_MB);
		ram_hit = (remap_ff ? (mb == rbd_pkg::LOW_MB) : (mb == rbd_pkg::RAM_BOOT_MB))
			&& (cpu_addr[rbd_pkg::MB_LO-1:rbd_pkg::RAM_TOP] == '0);
		ext_off = cpu_addr - rbd_pkg::EXT_BASE;
		if (bank_size_sel == rbd_pkg::BANKS_1M) begin
			bank_idx = ext_off[rbd_pkg::SHIFT_1M +: 12];
			bank_cnt = rbd_pkg::CNT_8;
		end else if (bank_size_sel == rbd_pkg::BANKS_4M) begin
			bank_idx = {2'h0, ext_off[rbd_pkg::SHIFT_4M +: 10]};
			bank_cnt = rbd_pkg::CNT_8;
		end else begin
			bank_idx = {4'h0, ext_off[rbd_pkg::SHIFT_16M +: 8]};
			bank_cnt = rbd_pkg::CNT_4;
		end
		bank_ok = remap_ff && (bank_idx < bank_cnt);
		if (cpu_size == rbd_pkg::SZ_BYTE) begin
			ram_be = rbd_pkg::BE_BYTE << cpu_addr[1:0];
		end else if (cpu_size == rbd_pkg::SZ_HALF) begin
			ram_be = rbd_pkg::BE_HALF << {cpu_addr[1], 1'b0};
		end else begin
			ram_be = rbd_pkg::BE_WORD;
		end
	end

	// sram is only touched on a fresh hit, so reserved space stays put
	assign ram_en = cpu_req && (state_ff == rbd_pkg::RBD_IDLE) && !sys_clr
		&& in_int && ram_hit;

	// transaction sequencing, one access outstanding at a time
	always_comb begin
		nxt_state = state_ff;
		nxt_remap = remap_ff;
		nxt_ack = 1'b0;
		nxt_dab = 1'b0;
		nxt_pab = 1'b0;
		nxt_ram_rd = 1'b0;
		nxt_rdata = rdata_ff;
		nxt_ebu_req = 1'b0;
		nxt_ebu_wr = ebu_wr_ff;
		nxt_ebu_size = ebu_size_ff;
		nxt_ebu_addr = ebu_addr_ff;
		nxt_ebu_wdata = ebu_wdata_ff;
		nxt_ebu_cs_n = ebu_cs_n_ff;
		nxt_per_req = 1'b0;
		nxt_per_wr = per_wr_ff;
		nxt_per_addr = per_addr_ff;
		nxt_per_wdata = per_wdata_ff;
		nxt_slot = slot_ff;
		nxt_hub = hub_ff;
		if (remap_ctrl_wr && remap_command_bit) begin
			nxt_remap = 1'b1;
		end
		case (state_ff)
			rbd_pkg::RBD_IDLE: begin
				if (cpu_req) begin
					if (in_int && cs0_hit) begin
						nxt_ebu_req = 1'b1;
						nxt_ebu_cs_n = 8'hFE;
						nxt_state = rbd_pkg::RBD_WAIT_EBU;
					end else if (in_int) begin
						nxt_ack = 1'b1;
						nxt_ram_rd = ram_hit && !cpu_write;
						nxt_rdata = '0;
					end else if (in_per) begin
						nxt_per_req = 1'b1;
						nxt_per_wr = cpu_write;
						nxt_per_addr = {cpu_addr[31:2], 2'h0};
						nxt_per_wdata = cpu_wdata;
						nxt_hub = (cpu_addr >= rbd_pkg::HUB_BASE);
						nxt_slot = cpu_addr[rbd_pkg::SLOT_HI:rbd_pkg::SLOT_LO];
						nxt_state = rbd_pkg::RBD_WAIT_PER;
						if (cpu_addr >= rbd_pkg::PER_RSV_BASE && cpu_addr < rbd_pkg::HUB_BASE) begin
							nxt_per_req = 1'b0;
							nxt_ack = 1'b1;
							nxt_rdata = '0;
							nxt_state = rbd_pkg::RBD_IDLE;
						end
					end else if (bank_ok) begin
						nxt_ebu_req = 1'b1;
						nxt_ebu_cs_n = ~(8'h01 << bank_idx[2:0]);
						nxt_state = rbd_pkg::RBD_WAIT_EBU;
					end else begin
						nxt_ack = 1'b1;
						nxt_rdata = '0; // no stale data leaks out on an abort
						nxt_dab = !cpu_instr;
						nxt_pab = cpu_instr;
					end
					if (nxt_ebu_req) begin
						nxt_ebu_wr = cpu_write;
						nxt_ebu_size = cpu_size;
						nxt_ebu_addr = cpu_addr;
						nxt_ebu_wdata = cpu_wdata;
					end
				end
			end
			rbd_pkg::RBD_WAIT_EBU: begin
				if (ebu_ack) begin
					nxt_ack = 1'b1;
					nxt_rdata = ebu_rdata;
					nxt_ebu_cs_n = 8'hFF;
					nxt_state = rbd_pkg::RBD_IDLE;
				end
			end
			rbd_pkg::RBD_WAIT_PER: begin
				if (per_ack) begin
					nxt_ack = 1'b1;
					nxt_rdata = per_rdata;
					nxt_state = rbd_pkg::RBD_IDLE;
				end
			end
			default: begin
				nxt_state = rbd_pkg::RBD_IDLE;
			end
		endcase
		// any reset returns the boot map and drops the access
		if (sys_clr) begin
			nxt_state = rbd_pkg::RBD_IDLE;
			nxt_remap = 1'b0;
			nxt_ack = 1'b0;
			nxt_dab = 1'b0;
			nxt_pab = 1'b0;
			nxt_ram_rd = 1'b0;
			nxt_ebu_req = 1'b0;
			nxt_per_req = 1'b0;
			nxt_ebu_cs_n = 8'hFF;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= rbd_pkg::RBD_IDLE;
			remap_ff <= 1'b0;
			ack_ff <= 1'b0;
			dab_ff <= 1'b0;
			pab_ff <= 1'b0;
			ram_rd_ff <= 1'b0;
			rdata_ff <= '0;
			ebu_req_ff <= 1'b0;
			ebu_wr_ff <= 1'b0;
			ebu_size_ff <= rbd_pkg::SZ_WORD;
			ebu_addr_ff <= '0;
			ebu_wdata_ff <= '0;
			ebu_cs_n_ff <= 8'hFF;
			per_req_ff <= 1'b0;
			per_wr_ff <= 1'b0;
			per_addr_ff <= '0;
			per_wdata_ff <= '0;
			slot_ff <= '0;
			hub_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			remap_ff <= nxt_remap;
			ack_ff <= nxt_ack;
			dab_ff <= nxt_dab;
			pab_ff <= nxt_pab;
			ram_rd_ff <= nxt_ram_rd;
			rdata_ff <= nxt_rdata;
			ebu_req_ff <= nxt_ebu_req;
			ebu_wr_ff <= nxt_ebu_wr;
			ebu_size_ff <= nxt_ebu_size;
			ebu_addr_ff <= nxt_ebu_addr;
			ebu_wdata_ff <= nxt_ebu_wdata;
			ebu_cs_n_ff <= nxt_ebu_cs_n;
			per_req_ff <= nxt_per_req;
			per_wr_ff <= nxt_per_wr;
			per_addr_ff <= nxt_per_addr;
			per_wdata_ff <= nxt_per_wdata;
			slot_ff <= nxt_slot;
			hub_ff <= nxt_hub;
		end
	end

	// word wide sram, answer straight from its read register
	rbd_sram u_ram (
		.clk(clk),
		.en(ram_en),
		.wr(cpu_write),
		.be(ram_be),
		.addr(cpu_addr[rbd_pkg::RAM_TOP-1:2]),
		.wdata(cpu_wdata),
		.rdata(ram_q)
	);

	// outputs
	assign core_reset = sys_clr;
	assign outputs_disabled = float_mode_ff;
	assign boot_bus_8bit = boot8_mode_ff;
	assign port_b_line_eighteen_gpio_en = !rst_hold_ff;
	assign remap_active = remap_ff;
	assign cpu_ack = ack_ff;
	assign cpu_rdata = ram_rd_ff ? ram_q : rdata_ff;
	assign data_abort = dab_ff;
	assign prefetch_abort = pab_ff;
	assign ebu_req = ebu_req_ff;
	assign ebu_write = ebu_wr_ff;
	assign ebu_size = ebu_size_ff;
	assign ebu_addr = ebu_addr_ff;
	assign ebu_wdata = ebu_wdata_ff;
	assign ebu_cs_n = ebu_cs_n_ff;
	assign per_req = per_req_ff;
	assign per_write = per_wr_ff;
	assign per_addr = per_addr_ff;
	assign per_wdata = per_wdata_ff;
	assign per_slot = slot_ff;
	assign per_hub_sel = hub_ff;

	// checks on the live behaviour
	remap_hold_a: assert property (
		@(posedge clk) disable iff (rst)
		remap_ff && !sys_clr |=> remap_ff)
		else $error("remap dropped without reset");
	remap_set_a: assert property (
		@(posedge clk) disable iff (rst)
		remap_ctrl_wr && remap_command_bit && !sys_clr |=> remap_active)
		else $error("remap command not taken");
	wdt_modes_a: assert property (
		@(posedge clk) disable iff (rst)
		watchdog_reset_req && !rst_dly_ff |=> !remap_active
			&& $stable(boot_bus_8bit) && $stable(outputs_disabled))
		else $error("watchdog reset disturbed modes");
	ram_cycle_a: assert property (
		@(posedge clk) disable iff (rst)
		ram_en |=> cpu_ack && !data_abort && !prefetch_abort)
		else $error("sram not answered in one cycle");
	ext_abort_a: assert property (
		@(posedge clk) disable iff (rst)
		cpu_req && state_ff == rbd_pkg::RBD_IDLE && !sys_clr && !in_int && !in_per
			&& !remap_ff |=> cpu_ack && (data_abort != prefetch_abort) && !ebu_req)
		else $error("undefined external access not aborted");
	per_abort_a: assert property (
		@(posedge clk) disable iff (rst)
		per_ack && state_ff == rbd_pkg::RBD_WAIT_PER && !sys_clr
			|=> cpu_ack && !data_abort && !prefetch_abort)
		else $error("peripheral access aborted");
	boot_fetch_a: assert property (
		@(posedge clk) disable iff (rst)
		cpu_req && state_ff == rbd_pkg::RBD_IDLE && !sys_clr && !remap_ff
			&& cpu_addr < 32'h0010_0000 |=> ebu_req && ebu_cs_n == 8'hFE)
		else $error("boot fetch not sent to chip select zero");
	strap_take_a: assert property (
		@(posedge clk) disable iff (rst)
		release_edge |=> boot_bus_8bit == $past(boot_hist_ff[0])
			&& outputs_disabled == $past(float_all_low))
		else $error("boot strap not latched at release");
	word_force_a: assert property (
		@(posedge clk) disable iff (rst)
		$rose(per_req) |-> per_addr[1:0] == 2'h0 ##1 !per_req)
		else $error("peripheral access not word aligned");
endmodule
`default_nettype wire

// ===== sim/rbd_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// external memory and peripheral bus stand-in; answers fast or slow
module rbd_far_end (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic ebu_req,
	input wire logic [31:0] ebu_addr,
	output logic ebu_ack,
	output logic [31:0] ebu_rdata,
	input wire logic per_req,
	input wire logic [31:0] per_addr,
	output logic per_ack,
	output logic [31:0] per_rdata
);
	logic [3:0] e_cnt_ff;
	logic [3:0] p_cnt_ff;
	// data is a pattern of the address; between answers the bus flips the last value every cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			e_cnt_ff <= 4'h0;
			p_cnt_ff <= 4'h0;
			ebu_ack <= 1'b0;
			per_ack <= 1'b0;
			ebu_rdata <= 32'h0;
			per_rdata <= 32'h0;
		end else begin
			e_cnt_ff <= ebu_req ? (slow ? 4'h4 : 4'h1) : (e_cnt_ff != 4'h0 ? e_cnt_ff - 4'h1 : 4'h0);
			p_cnt_ff <= per_req ? (slow ? 4'h4 : 4'h1) : (p_cnt_ff != 4'h0 ? p_cnt_ff - 4'h1 : 4'h0);
			ebu_ack <= (e_cnt_ff == 4'h1);
			per_ack <= (p_cnt_ff == 4'h1);
			ebu_rdata <= (e_cnt_ff == 4'h1) ? ebu_addr ^ 32'h5A5A_5A5A : ~ebu_rdata;
			per_rdata <= (p_cnt_ff == 4'h1) ? per_addr ^ 32'hC3C3_C3C3 : ~per_rdata;
		end
	end
endmodule
`default_nettype wire

// ===== sim/reset_boot_address_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module reset_boot_address_decoder_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wdr = 1'b0;
	logic fl_n = 1'b1;
	logic bw = 1'b1;
	logic rc_wr = 1'b0;
	logic rc_bit = 1'b0;
	logic [1:0] bsel = 2'h0;
	logic slow = 1'b0;
	logic cpu_req = 1'b0;
	logic cpu_instr = 1'b0;
	logic cpu_write = 1'b0;
	logic [1:0] cpu_size = 2'h2;
	logic [31:0] cpu_addr = 32'h0;
	logic [31:0] cpu_wdata = 32'h0;
	logic core_reset, od, bw8, gpio_en, remap_active, cpu_ack, data_abort, prefetch_abort;
	logic [31:0] cpu_rdata, ebu_addr, ebu_rdata, per_addr, per_rdata;
	logic ebu_req, ebu_ack, per_req, per_ack, hub;
	logic [7:0] ebu_cs_n, slot, cs_seen, slot_seen;
	logic [31:0] pa_seen;
	logic hub_seen;
	int fwd = 0;
	int err_total = 0;
	int compares = 0;
	int k;
	int sh;
	logic [31:0] a;
	always #2 clk = ~clk;
	rbd_decoder dut (.clk(clk), .rst(rst), .watchdog_reset_req(wdr), .float_outputs_strap_n(fl_n),
		.boot_width_strap(bw), .core_reset(core_reset), .outputs_disabled(od), .boot_bus_8bit(bw8),
		.port_b_line_eighteen_gpio_en(gpio_en), .remap_ctrl_wr(rc_wr), .remap_command_bit(rc_bit),
		.remap_active(remap_active), .bank_size_sel(bsel), .cpu_req(cpu_req), .cpu_instr(cpu_instr),
		.cpu_write(cpu_write), .cpu_size(cpu_size), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
		.cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .data_abort(data_abort),
		.prefetch_abort(prefetch_abort), .ebu_req(ebu_req), .ebu_write(), .ebu_size(),
		.ebu_addr(ebu_addr), .ebu_wdata(), .ebu_cs_n(ebu_cs_n), .ebu_ack(ebu_ack),
		.ebu_rdata(ebu_rdata), .per_req(per_req), .per_write(), .per_addr(per_addr), .per_wdata(),
		.per_slot(slot), .per_hub_sel(hub), .per_ack(per_ack), .per_rdata(per_rdata));
	rbd_far_end far (.clk(clk), .rst(rst), .slow(slow), .ebu_req(ebu_req), .ebu_addr(ebu_addr),
		.ebu_ack(ebu_ack), .ebu_rdata(ebu_rdata), .per_req(per_req), .per_addr(per_addr),
		.per_ack(per_ack), .per_rdata(per_rdata));
	// note what each forwarded request carried
	always @(posedge clk) begin
		if (ebu_req === 1'b1 || per_req === 1'b1) begin
			fwd <= fwd + 1;
			cs_seen <= ebu_cs_n;
			pa_seen <= per_addr;
			slot_seen <= slot;
			hub_seen <= hub;
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// one access; sizes 0 byte, 1 half, 2 word; eab is {prefetch, data} abort
	task automatic xfer(input logic ins, input logic wr, input logic [1:0] sz, input logic [31:0] ad,
		input logic [31:0] wd, input logic [31:0] ed, input logic [1:0] eab);
		int n;
		n = 0;
		cpu_instr = ins;
		cpu_write = wr;
		cpu_size = sz;
		cpu_addr = ad;
		cpu_wdata = wd;
		cpu_req = 1'b1;
		@(negedge clk);
		cpu_req = 1'b0;
		while (cpu_ack !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk("cpu_ack", {31'h0, cpu_ack}, 32'h1);
		if (!wr)
			chk("cpu_rdata", cpu_rdata, ed);
		chk("abort", {30'h0, prefetch_abort, data_abort}, {30'h0, eab});
		@(negedge clk);
	endtask
	// straps held through the whole reset, clock running all along
	task automatic pin_reset(input logic f, input logic b, input logic w);
		int n;
		n = 0;
		@(negedge clk);
		rst = 1'b1;
		wdr = w;
		fl_n = f;
		bw = b;
		#1 chk("core_reset async", {31'h0, core_reset}, 32'h1);
		repeat (16) @(negedge clk);
		rst = 1'b0;
		wdr = 1'b0;
		@(posedge clk);
		#1 chk("core_reset held", {31'h0, core_reset}, 32'h1);
		while (core_reset !== 1'b0 && n < 10) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		chk("tristate", {31'h0, od}, {31'h0, ~f});
		chk("boot8", {31'h0, bw8}, {31'h0, b});
		chk("gpio_en", {31'h0, gpio_en}, 32'h1);
		chk("remap", {31'h0, remap_active}, 32'h0);
	endtask
	initial begin
		#200000;
		err_total++;
		print_verdict();
	end
	initial begin
		pin_reset(1'b1, 1'b1, 1'b0);
		$display("test reset done");
		xfer(0, 1, 2'h2, 32'h0030_0004, 32'h1122_3344, 0, 0);
		xfer(0, 1, 2'h0, 32'h0030_0005, 32'h0000_AA00, 0, 0);
		xfer(0, 1, 2'h1, 32'h0030_0006, 32'hBEEF_0000, 0, 0);
		xfer(0, 0, 2'h2, 32'h0030_0004, 0, 32'hBEEF_AA44, 0);
		xfer(1, 0, 2'h2, 32'h0, 0, 32'h5A5A_5A5A, 0);
		chk("cs boot", {24'h0, cs_seen}, 32'h0000_00FE);
		k = fwd;
		xfer(0, 0, 2'h2, 32'h0040_0000, 0, 0, 2'h1);
		xfer(1, 0, 2'h2, 32'h0040_0000, 0, 0, 2'h2);
		chk("not forwarded", fwd, k);
		$display("test boot map done");
		rc_wr = 1'b1;
		rc_bit = 1'b1;
		@(negedge clk);
		rc_wr = 1'b0;
		@(negedge clk);
		chk("remap", {31'h0, remap_active}, 32'h1);
		xfer(0, 0, 2'h2, 32'h0000_0004, 0, 32'hBEEF_AA44, 0);
		xfer(0, 1, 2'h2, 32'h0000_0010, 32'hCAFE_F00D, 0, 0);
		xfer(0, 0, 2'h2, 32'h0000_0010, 0, 32'hCAFE_F00D, 0);
		xfer(0, 0, 2'h2, 32'h0030_0004, 0, 32'h0, 0);
		$display("test remap done");
		for (int s = 0; s < 4; s++) begin
			bsel = s[1:0];
			sh = (s >= 2) ? 24 : 20 + 2 * s;
			for (int b = 0; b < ((s >= 2) ? 4 : 8); b++) begin
				slow = b[0];
				a = 32'h0040_0000 + (32'(b) << sh) + 32'h10;
				xfer(0, 0, 2'h2, a, 0, a ^ 32'h5A5A_5A5A, 0);
				chk("bank cs", {24'h0, cs_seen}, {24'h0, ~(8'h01 << b)});
			end
			a = 32'h0040_0000 + (((s >= 2) ? 32'h4 : 32'h8) << sh);
			xfer(0, 0, 2'h2, a, 0, 0, 2'h1);
		end
		$display("test banks done");
		xfer(0, 0, 2'h0, 32'hFFFD_0003, 0, 32'hFFFD_0000 ^ 32'hC3C3_C3C3, 0);
		chk("per addr", pa_seen, 32'hFFFD_0000);
		chk("per slot", {23'h0, slot_seen, hub_seen}, {23'h0, 8'hF4, 1'b0});
		xfer(0, 1, 2'h1, 32'hFFFF_F106, 32'h0, 0, 0);
		chk("hub", {pa_seen[31:1], hub_seen}, 32'hFFFF_F105);
		k = fwd;
		xfer(0, 0, 2'h2, 32'hFFFF_C010, 0, 32'h0, 0);
		chk("not forwarded", fwd, k);
		$display("test peripherals done");
		@(negedge clk);
		wdr = 1'b1;
		fl_n = 1'b0;
		bw = 1'b0;
		@(negedge clk);
		chk("core_reset wd", {31'h0, core_reset}, 32'h1);
		repeat (12) @(negedge clk);
		wdr = 1'b0;
		@(negedge clk);
		chk("modes kept", {30'h0, od, bw8}, 32'h1);
		chk("remap cleared", {31'h0, remap_active}, 32'h0);
		$display("test watchdog done");
		pin_reset(1'b0, 1'b0, 1'b1);
		$display("test pin over watchdog done");
		print_verdict();
	end
endmodule
`default_nettype wire
